/* File: rtl/pc_calc_if.sv */
// carrier between the counter register and its address adder
`timescale 1ns/1ns
interface pc_calc_if;
  logic [15:0] pc;
  logic [2:0]  len;
  logic [7:0]  disp;
  logic [15:0] seq_addr;
  logic [15:0] rel_target;

  modport requester  (output pc, output len, output disp, input seq_addr, input rel_target);
  modport calculator (input pc, input len, input disp, output seq_addr, output rel_target);
endinterface : pc_calc_if

/* File: rtl/pc_next_address.sv */
// program counter with sequential, relative and absolute next-address selection
`timescale 1ns/1ns
// How it works
// - no branch: advance by instruction byte count
// - taken branch loads target instead of increment
// - relative target counts from next instruction start
// - displacement signed, reach -128 to +127
// - bit 7 is sign, fills upper bits
// - relative for short branch, conditionals when met
// - absolute call/branch loads 16-bit immediate
// - absolute targets reach the whole address space
module pc_next_address
  import pc_next_pkg::*;
#(
  parameter int MAX_LEN = 3
)(
  // clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst_n,
  // decoder side
  input  wire logic            instr_valid,
  input  wire logic [2:0]      instr_len,
  input  branch_kind_type      branch_kind,
  input  wire logic            cond_met,
  input  wire logic [7:0]      branch_displacement,
  input  wire logic [15:0]     branch_immediate,
  // fetch side
  output logic [15:0]          pc,
  output logic                 branch_taken,
  // stack side
  output logic [15:0]          return_addr,
  output logic                 return_valid
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  // instr_len is three bits wide, so no instruction can exceed seven bytes
  if (MAX_LEN < int'(LEN_MIN) || MAX_LEN > 7) begin : g_len_check
    $error("MAX_LEN must lie between 1 and 7");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [15:0] pc_reg;
  logic [15:0] pc_next;
  logic [15:0] ret_reg;
  logic        ret_valid_reg;
  logic        taken_reg;

  // ----------------------------------------------------------------------
  // adders
  // ----------------------------------------------------------------------
  // one adder chain serves both the sequential step and the relative target
  pc_calc_if calc_bus ();

  assign calc_bus.pc   = pc_reg;
  assign calc_bus.len  = instr_len;
  assign calc_bus.disp = branch_displacement;

  pc_target_calc u_calc (
    .calc (calc_bus.calculator)
  );

  // ----------------------------------------------------------------------
  // branch decode and selection
  // ----------------------------------------------------------------------
  wire take_rel;
  wire take_abs;
  wire is_call;

  // a conditional branch that fails falls through to the sequential path
  assign take_rel = instr_valid && ((branch_kind == BR_REL_UNCOND) ||
                    ((branch_kind == BR_REL_COND) && cond_met));
  assign take_abs = instr_valid && ((branch_kind == BR_ABS_JUMP) ||
                    (branch_kind == BR_ABS_CALL));
  assign is_call  = instr_valid && (branch_kind == BR_ABS_CALL);

  // absolute forms are checked first; the decoder never flags two forms at once
  // limitation: instr_len is trusted, a length above MAX_LEN is not caught here
  // immediate goes in unchanged, so no range limit applies
  assign pc_next = take_abs    ? branch_immediate :
                   take_rel    ? calc_bus.rel_target :
                   instr_valid ? calc_bus.seq_addr :
                   pc_reg;

  // ----------------------------------------------------------------------
  // next values of the flags
  // ----------------------------------------------------------------------
  wire        taken_next;
  wire        ret_valid_next;
  wire [15:0] ret_next;

  // the flag follows the selection, so it never disagrees with the counter
  assign taken_next     = take_rel || take_abs;
  // one-cycle pulse: any cycle without a call clears it
  assign ret_valid_next = is_call;
  // the old return address stands until the next call overwrites it
  assign ret_next       = is_call ? calc_bus.seq_addr : ret_reg;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  // counter and branch indication
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg    <= PC_RESET;
      taken_reg <= 1'b0;
    end else begin
      pc_reg    <= pc_next;
      taken_reg <= taken_next;
    end
  end

  // return address leaves on the same edge the counter loads the target
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ret_reg       <= RET_RESET;
      ret_valid_reg <= 1'b0;
    end else begin
      ret_valid_reg <= ret_valid_next;
      ret_reg       <= ret_next;
    end
  end

  assign pc           = pc_reg;
  assign branch_taken = taken_reg;
  assign return_addr  = ret_reg;
  assign return_valid = ret_valid_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_seq_advance: assert property (
    instr_valid && branch_kind == BR_NONE
    |=> pc == 16'($past(pc) + {13'h0000, $past(instr_len)}) && !branch_taken)
    else $error("counter did not advance by instruction length");

  a_idle_hold: assert property (
    !instr_valid |=> $stable(pc) && !branch_taken)
    else $error("counter moved without an instruction");

  a_branch_load: assert property (
    instr_valid && (branch_kind == BR_REL_UNCOND || branch_kind == BR_ABS_JUMP ||
                    branch_kind == BR_ABS_CALL ||
                    (branch_kind == BR_REL_COND && cond_met))
    |=> branch_taken)
    else $error("taken branch not flagged");

  a_back_to_back: assert property (
    (instr_valid && branch_kind == BR_NONE) ##1 (instr_valid && branch_kind == BR_NONE)
    |=> pc == 16'($past(pc, 2) + {13'h0000, $past(instr_len, 2)}
                  + {13'h0000, $past(instr_len)}))
    else $error("back to back instructions lost a length");

  a_rel_next_start: assert property (
    take_rel |=> pc == 16'($past(pc) + {13'h0000, $past(instr_len)}
                     + sign_extend($past(branch_displacement))))
    else $error("relative target not based on next instruction");

  a_rel_span: assert property (
    take_rel |=> ($signed(16'(pc - 16'($past(pc) + {13'h0000, $past(instr_len)}))) >= -128)
             && ($signed(16'(pc - 16'($past(pc) + {13'h0000, $past(instr_len)}))) <= 127))
    else $error("relative target outside signed byte reach");

  a_sign_fill: assert property (
    take_rel && branch_displacement[7]
    |=> 16'(pc - 16'($past(pc) + {13'h0000, $past(instr_len)})) >= 16'hFF80)
    else $error("negative displacement not sign filled");

  a_cond_skip: assert property (
    instr_valid && branch_kind == BR_REL_COND && !cond_met
    |=> pc == 16'($past(pc) + {13'h0000, $past(instr_len)}) && !branch_taken)
    else $error("failed condition still branched");

  a_abs_load: assert property (
    take_abs |=> pc == $past(branch_immediate) && branch_taken)
    else $error("absolute target not loaded");

  a_call_return: assert property (
    is_call |=> return_valid && pc == $past(branch_immediate)
             && return_addr == 16'($past(pc) + {13'h0000, $past(instr_len)}))
    else $error("call return address wrong or late");

  a_ret_only_call: assert property (
    !is_call |=> !return_valid && $stable(return_addr))
    else $error("return address changed without a call");

  a_rel_zero_disp: assert property (
    take_rel && branch_displacement == 8'h00
    |=> pc == 16'($past(pc) + {13'h0000, $past(instr_len)}))
    else $error("zero displacement did not land on next instruction");

  a_cond_take: assert property (
    instr_valid && branch_kind == BR_REL_COND && cond_met
    |=> pc == 16'($past(pc) + {13'h0000, $past(instr_len)}
                  + sign_extend($past(branch_displacement))) && branch_taken)
    else $error("met condition did not branch relative");

  a_uncond_no_cond: assert property (
    instr_valid && branch_kind == BR_REL_UNCOND && !cond_met
    |=> branch_taken)
    else $error("short branch waited on a condition");

  a_zero_fill: assert property (
    take_rel && !branch_displacement[7]
    |=> 16'(pc - 16'($past(pc) + {13'h0000, $past(instr_len)})) <= 16'h007F)
    else $error("positive displacement not zero filled");

  a_abs_cond_free: assert property (
    instr_valid && branch_kind == BR_ABS_JUMP && !cond_met
    |=> pc == $past(branch_immediate) && branch_taken)
    else $error("absolute branch depended on a condition");

  a_abs_edge_reach: assert property (
    take_abs && (branch_immediate >= 16'hFF00 || branch_immediate <= 16'h00FF)
    |=> pc == $past(branch_immediate))
    else $error("absolute target at the space edge not reached");

  a_call_flags: assert property (
    is_call |=> return_valid && branch_taken)
    else $error("call did not raise both pulses together");

endmodule : pc_next_address

/* File: rtl/pc_next_pkg.sv */
// shared constants, types and helpers for the program counter next-address logic
package pc_next_pkg;

  // ----------------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------------
  localparam int          ADDR_W      = 16;
  localparam int          DISP_W      = 8;
  localparam int          LEN_W       = 3;
  localparam int          DISP_SIGN   = 7;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] RET_RESET   = 16'h0000;
  localparam logic [2:0]  LEN_MIN     = 3'h1;

  // ----------------------------------------------------------------------
  // branch forms reported by the decoder
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    BR_NONE,
    BR_REL_UNCOND,
    BR_REL_COND,
    BR_ABS_JUMP,
    BR_ABS_CALL
  } branch_kind_type;

  // sign bit copied into every upper address bit
  function automatic logic [15:0] sign_extend(input logic [7:0] disp);
    sign_extend = {{8{disp[DISP_SIGN]}}, disp};
  endfunction : sign_extend

endpackage : pc_next_pkg

/* File: rtl/pc_target_calc.sv */
// address adders: next sequential address and relative branch target
`timescale 1ns/1ns
module pc_target_calc
  import pc_next_pkg::*;
(
  // operands in, addresses out
  pc_calc_if.calculator calc
);

  // ----------------------------------------------------------------------
  // adders
  // ----------------------------------------------------------------------
  wire [15:0] len_wide;
  wire [15:0] disp_wide;

  // carry out of bit 15 is dropped so addresses wrap in the 64 KiB space
  assign len_wide        = {13'h0000, calc.len};
  assign calc.seq_addr   = calc.pc + len_wide;
  assign disp_wide       = sign_extend(calc.disp);
  assign calc.rel_target = calc.seq_addr + disp_wide;

endmodule : pc_target_calc

/* File: sim/fetch_model.sv */
// decoder and fetch unit model that feeds the next-address block
`timescale 1ns/1ns
module fetch_model
  import pc_next_pkg::*;
(
  // clock
  input  wire logic        sys_clk,
  // decoder outputs
  output logic             instr_valid,
  output logic [2:0]       instr_len,
  output branch_kind_type  branch_kind,
  output logic             cond_met,
  output logic [7:0]       branch_displacement,
  output logic [15:0]      branch_immediate
);
  // -------------------------------------------------------------------
  // idle state at time zero
  // -------------------------------------------------------------------
  initial begin
    instr_valid         = 1'b0;
    instr_len           = 3'h1;
    branch_kind         = BR_NONE;
    cond_met            = 1'b0;
    branch_displacement = 8'h5A;
    branch_immediate    = 16'hA5A5;
  end

  // one instruction held over one sampling edge
  task issue(input logic [2:0] len, input branch_kind_type kind, input logic cond,
             input logic [7:0] disp, input logic [15:0] imm);
    instr_valid         = 1'b1;
    instr_len           = len;
    branch_kind         = kind;
    cond_met            = cond;
    branch_displacement = disp;
    branch_immediate    = imm;
    @(posedge sys_clk);
    #1;
  endtask : issue

  // released displacement, immediate and condition flip so a stale value is never mistaken for a live one; length and kind hold
  task idle;
    instr_valid         = 1'b0;
    branch_displacement = ~branch_displacement;
    branch_immediate    = ~branch_immediate;
    cond_met            = ~cond_met;
    @(posedge sys_clk);
    #1;
  endtask : idle
endmodule : fetch_model

/* File: sim/program_counter_next_address_test.sv */
// self-checking testbench for the program counter next-address block
`timescale 1ns/1ns
module program_counter_next_address_test;
  import pc_next_pkg::*;
  logic            sys_clk = 1'b0;
  logic            rst_n   = 1'b0;
  logic            instr_valid, cond_met, branch_taken, return_valid;
  logic [2:0]      instr_len;
  branch_kind_type branch_kind;
  logic [7:0]      branch_displacement;
  logic [15:0]     branch_immediate, pc, return_addr;
  logic [15:0]     exp_pc  = 16'h0000;
  logic [15:0]     exp_ret = 16'h0000;
  int              bad_count = 0;
  int              checks    = 0;

  always #25 sys_clk = ~sys_clk;

  fetch_model u_fetch_model (.sys_clk(sys_clk), .instr_valid(instr_valid),
    .instr_len(instr_len), .branch_kind(branch_kind), .cond_met(cond_met),
    .branch_displacement(branch_displacement), .branch_immediate(branch_immediate));
  pc_next_address u_pc_next_address (.sys_clk(sys_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_len(instr_len), .branch_kind(branch_kind),
    .cond_met(cond_met), .branch_displacement(branch_displacement),
    .branch_immediate(branch_immediate), .pc(pc), .branch_taken(branch_taken),
    .return_addr(return_addr), .return_valid(return_valid));

  task check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task complete_run;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one instruction; expectation worked out here, never read back
  task step(input logic [2:0] len, input branch_kind_type k, input logic c,
            input logic [7:0] d, input logic [15:0] imm);
    logic [15:0] nxt;
    logic        tk;
    nxt = exp_pc + {13'h0000, len};
    tk  = (k == BR_REL_UNCOND) || (k == BR_ABS_JUMP) || (k == BR_ABS_CALL) ||
          (k == BR_REL_COND && c);
    if (k == BR_ABS_CALL) exp_ret = nxt;
    exp_pc = !tk ? nxt : (k == BR_ABS_JUMP || k == BR_ABS_CALL) ? imm
             : nxt + {{8{d[7]}}, d};
    u_fetch_model.issue(len, k, c, d, imm);
    check(pc, exp_pc);
    check({15'h0000, branch_taken}, {15'h0000, tk});
    check({15'h0000, return_valid}, {15'h0000, k == BR_ABS_CALL});
    check(return_addr, exp_ret);
  endtask : step

  task sequential_run;
    step(3'h1, BR_NONE, 1'b1, 8'h10, 16'h1234);
    step(3'h2, BR_NONE, 1'b0, 8'h80, 16'hFFFF);
    step(3'h3, BR_NONE, 1'b1, 8'h7F, 16'h0000);
    u_fetch_model.idle();
    check(pc, exp_pc);
  endtask : sequential_run

  task relative_run;
    step(3'h2, BR_REL_UNCOND, 1'b0, 8'hFE, 16'h4000);
    step(3'h2, BR_REL_UNCOND, 1'b0, 8'h80, 16'h4000);
    step(3'h2, BR_REL_UNCOND, 1'b0, 8'h7F, 16'h4000);
    step(3'h1, BR_REL_UNCOND, 1'b1, 8'h00, 16'h4000);
    step(3'h2, BR_REL_COND, 1'b0, 8'h40, 16'h4000);
    step(3'h3, BR_REL_COND, 1'b1, 8'hC0, 16'h4000);
    step(3'h2, BR_REL_COND, 1'b1, 8'h80, 16'h4000);
    u_fetch_model.idle();
    check(pc, exp_pc);
    check({15'h0000, branch_taken}, 16'h0000);
  endtask : relative_run

  task absolute_run;
    step(3'h3, BR_ABS_JUMP, 1'b0, 8'h05, 16'hFFFF);
    step(3'h3, BR_ABS_CALL, 1'b0, 8'h05, 16'h8000);
    step(3'h1, BR_NONE, 1'b0, 8'h05, 16'h0000);
    step(3'h3, BR_ABS_CALL, 1'b1, 8'hFF, 16'h0000);
    u_fetch_model.idle();
    check({15'h0000, return_valid}, 16'h0000);
    check(return_addr, exp_ret);
  endtask : absolute_run

  // every output at its reset value
  task check_reset;
    check(pc, PC_RESET);
    check({15'h0000, branch_taken}, 16'h0000);
    check({15'h0000, return_valid}, 16'h0000);
    check(return_addr, RET_RESET);
  endtask : check_reset

  // reset in mid-run right after a call; the counter restarts from its reset value
  task reset_run;
    step(3'h3, BR_ABS_CALL, 1'b0, 8'h00, 16'h2468);
    rst_n = 1'b0;
    u_fetch_model.idle();
    check_reset();
    rst_n   = 1'b1;
    exp_pc  = PC_RESET;
    exp_ret = RET_RESET;
    step(3'h2, BR_NONE, 1'b0, 8'h00, 16'h0000);
  endtask : reset_run

  initial begin
    #(50 * 400);
    bad_count++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    #1;
    check_reset();
    rst_n = 1'b1;
    sequential_run();
    relative_run();
    absolute_run();
    reset_run();
    complete_run();
  end
endmodule : program_counter_next_address_test
